// File: sct_pkg.sv
// Shared constants for the six-channel PWM timer.
package sct_pkg;
  // Number of channels and register widths.
  localparam int          SCT_NCH       = 6;
  localparam int          SCT_CW        = 16;
  // Register byte offsets on the bus.
  localparam logic [11:0] SCT_TSC_OFF   = 12'h000;
  localparam logic [11:0] SCT_CNT_OFF   = 12'h004;
  localparam logic [11:0] SCT_MOD_OFF   = 12'h008;
  localparam logic [11:0] SCT_CSC_BASE  = 12'h010;
  localparam logic [11:0] SCT_CMP_BASE  = 12'h030;
  localparam logic [11:0] SCT_STRIDE    = 12'h004;
  // Timer status and control field positions.
  localparam int          SCT_TSC_TOF   = 7;
  localparam int          SCT_TSC_OVERFLOW_IRQ_ENABLE  = 6;
  localparam int          SCT_TSC_HALT  = 5;
  localparam int          SCT_TSC_TRST  = 4;
  // Channel status and control field positions.
  localparam int          SCT_CS_FLAG   = 7;
  localparam int          SCT_CS_IE     = 6;
  localparam int          SCT_CS_MSB    = 5;
  localparam int          SCT_CS_MSA    = 4;
  localparam int          SCT_CS_ELSB   = 3;
  localparam int          SCT_CS_ELSA   = 2;
  localparam int          SCT_CS_TOV    = 1;
  localparam int          SCT_CS_MAX    = 0;
  // Prescaler code that selects the external clock pin.
  localparam logic [2:0]  SCT_PS_EXT    = 3'h7;
  // Largest divider exponent, divide by 64.
  localparam logic [2:0]  SCT_PS_MAXDIV = 3'h6;
  // Reset values.
  localparam logic [15:0] SCT_MOD_RST   = 16'hFFFF;
  localparam logic [6:0]  SCT_CSC_RST   = 7'h00;
  localparam logic [2:0]  SCT_PS_RST    = 3'h0;
  // Edge and level codes.
  localparam logic [1:0]  SCT_ELS_OFF   = 2'h0;
  localparam logic [1:0]  SCT_ELS_RISE  = 2'h1;
  localparam logic [1:0]  SCT_ELS_FALL  = 2'h2;
  localparam logic [1:0]  SCT_ELS_TOG   = 2'h1;
  localparam logic [1:0]  SCT_ELS_CLR   = 2'h2;
  localparam logic [1:0]  SCT_ELS_SET   = 2'h3;
endpackage

// File: sct_tick_if.sv
// Timer clock tick interface between the core and the clock selector.
`timescale 1ns/1ns
interface sct_tick_if;
  logic       halt;     // Counting is frozen while high.
  logic       clr;      // Clears the prescaler.
  logic [2:0] sel;      // Prescaler select code.
  logic       ext_pin;  // Raw external clock pin.
  logic       tick;     // One-cycle counter enable.
  modport sel_end  (input halt, input clr, input sel, input ext_pin,
                    output tick);
  modport core_end (output halt, output clr, output sel, output ext_pin,
                    input tick);
endinterface

// File: sct_clock_select.sv
// Prescaler and external clock selector for the six-channel timer.
`timescale 1ns/1ns
module sct_clock_select
  import sct_pkg::*;
(
  input  wire logic CORE_CLK,
  input  wire logic RST_B,
  sct_tick_if.sel_end tk
);
  // Synchroniser stages and edge history for the external clock.
  logic       ext_meta_reg;
  logic       ext_sync_reg;
  logic       ext_last_reg;
  // Prescaler counter, held while the timer is halted.
  logic [5:0] pre_reg;
  logic [5:0] pre_next;
  logic [5:0] div_mask;
  logic       ext_rise;
  logic       int_hit;

  // The pin is asynchronous, so it passes two flip-flops first.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      ext_last_reg <= 1'b0;
    end else begin
      ext_meta_reg <= tk.ext_pin;
      ext_sync_reg <= ext_meta_reg;
      ext_last_reg <= ext_sync_reg;
    end
  end

  // Divide-by-2^n: tick whenever the low n prescaler bits are all ones.
  assign div_mask = 6'h3F >> (SCT_PS_MAXDIV - tk.sel);
  assign int_hit  = (pre_reg & div_mask) == div_mask;
  assign ext_rise = ext_sync_reg & ~ext_last_reg;
  assign pre_next = tk.clr ? 6'h00 : (tk.halt ? pre_reg : pre_reg + 6'h01);

  // Prescaler advances only while the timer runs.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pre_reg <= 6'h00;
    end else begin
      pre_reg <= pre_next;
    end
  end

  assign tk.tick = ~tk.halt & ~tk.clr &
                   ((tk.sel == SCT_PS_EXT) ? ext_rise : int_hit);
endmodule

// File: sct_timer.sv
// Six-channel PWM timer core with AHB-Lite register access.
`timescale 1ns/1ns
module sct_timer
  import sct_pkg::*;
#(
  parameter int NCH = SCT_NCH,
  parameter int CW  = SCT_CW
) (
  input  wire logic          CORE_CLK,
  input  wire logic          RST_B,
  input  wire logic          HSEL,
  input  wire logic [31:0]   HADDR,
  input  wire logic [1:0]    HTRANS,
  input  wire logic          HWRITE,
  input  wire logic [2:0]    HSIZE,
  input  wire logic [31:0]   HWDATA,
  input  wire logic          HREADY,
  output logic      [31:0]   HRDATA,
  output logic               HREADYOUT,
  output logic               HRESP,
  input  wire logic          WAIT_MODE,
  input  wire logic          STOP_MODE,
  input  wire logic          BREAK_STATE,
  input  wire logic          BREAK_CLEAR_ENABLE,
  input  wire logic          EXT_CLK_PIN,
  output logic               EXT_CLK_FORCE_INPUT,
  input  wire logic [NCH-1:0] CH_PIN_IN,
  output logic      [NCH-1:0] CH_PIN_OUT,
  output logic      [NCH-1:0] CH_PIN_OE,
  output logic               TIMER_IRQ,
  output logic               WAKE_REQ
);
  localparam int NP = NCH / 2;  // Number of linkable pairs.

  // Steps a two-step clearable flag; returns {flag, armed}.
  // A new event wins over the clear and disarms the sequence.
  function automatic logic [1:0] flag_step(input logic flag,
                                           input logic arm,
                                           input logic set,
                                           input logic rd,
                                           input logic wr0,
                                           input logic ok);
    logic [1:0] r;
    r = {flag, arm};
    if (set) begin
      r = 2'b10;
    end else if (arm && wr0 && ok) begin
      r = 2'b00;
    end else if (rd && ok) begin
      r = {flag, 1'b1};
    end
    return r;
  endfunction

  // Byte address of a per-channel register.
  function automatic logic [11:0] ch_addr(input logic [11:0] base,
                                          input int idx);
    return base + SCT_STRIDE * 12'(idx);
  endfunction

  // Timer status and control state.
  logic              tof_reg;        // Overflow flag.
  logic              tof_arm_reg;    // Overflow flag read while set.
  logic              overflow_irq_enable_reg;       // Overflow request enable.
  logic              halt_reg;       // Counter halt bit.
  logic [2:0]        ps_reg;         // Prescaler select.
  logic [CW-1:0]     cnt_reg;        // Counter.
  logic [CW-1:0]     mod_reg;        // Modulo value.
  // Channel state.
  logic [6:0]        ctl_reg [NCH];  // Channel control without the flag.
  logic [CW-1:0]     cmp_reg [NCH];  // Compare or capture values.
  logic [NCH-1:0]    chf_reg;        // Channel flags.
  logic [NCH-1:0]    chf_arm_reg;    // Channel flags read while set.
  logic [NCH-1:0]    out_reg;        // Channel pin levels.
  // Pair buffering state.
  logic [NP-1:0]     sel_reg;        // Odd member currently governs.
  logic [NP-1:0]     pend_reg;       // Odd member written last.
  logic [NP-1:0]     pend_next;
  logic [NP-1:0]     linked;
  // Pin synchronisers.
  logic [NCH-1:0]    pin_meta_reg;
  logic [NCH-1:0]    pin_sync_reg;
  logic [NCH-1:0]    pin_last_reg;
  // Bus data phase and request.
  logic              wr_pend_reg;
  logic [11:0]       wr_addr_reg;
  logic [31:0]       hrdata_reg;
  logic              irq_reg;

  sct_tick_if tk();

  // Address phase qualification; in wait the bus sees an empty map.
  logic        acc;
  logic        acc_rd;
  logic [11:0] a_addr;
  logic        flag_ok;
  assign acc     = HSEL & HTRANS[1] & HREADY & ~WAIT_MODE;
  assign acc_rd  = acc & ~HWRITE;
  assign a_addr  = HADDR[11:0];
  assign flag_ok = ~BREAK_STATE | BREAK_CLEAR_ENABLE;

  // Write decode in the data phase.
  logic wr_tsc;
  logic wr_mod;
  logic trst;
  assign wr_tsc = wr_pend_reg & (wr_addr_reg == SCT_TSC_OFF);
  assign wr_mod = wr_pend_reg & (wr_addr_reg == SCT_MOD_OFF);
  assign trst   = wr_tsc & HWDATA[SCT_TSC_TRST];

  // Clock selection and counter tick.
  // stop freezes counting.
  assign tk.halt    = halt_reg | STOP_MODE | BREAK_STATE;
  assign tk.clr     = trst;
  assign tk.sel     = ps_reg;
  assign tk.ext_pin = EXT_CLK_PIN;

  sct_clock_select u_clk (
    .CORE_CLK (CORE_CLK),
    .RST_B    (RST_B),
    .tk       (tk)
  );

  logic ovf;
  assign ovf = tk.tick & (cnt_reg == mod_reg);

  // Per-channel wires.
  logic [NCH-1:0] dis;       // Odd member of a linked pair.
  logic [NCH-1:0] oc_mode;   // Output compare or PWM.
  logic [NCH-1:0] cap_mode;  // Input capture.
  logic [NCH-1:0] match;
  logic [NCH-1:0] cap_ev;
  logic [NCH-1:0] wr_csc;
  logic [NCH-1:0] wr_cmp;
  logic [NCH-1:0] rd_set;
  logic [NCH-1:0] pin_rise;
  logic [NCH-1:0] pin_fall;
  logic [31:0]    rd_ch [NCH];
  logic [CW-1:0]  cmp_val [NCH];

  assign pin_rise = pin_sync_reg & ~pin_last_reg;
  assign pin_fall = ~pin_sync_reg & pin_last_reg;

  for (genvar p = 0; p < NP; p++) begin : g_pair
    assign linked[p]    = ctl_reg[2*p][SCT_CS_MSB];
    assign pend_next[p] = ~linked[p] ? 1'b0 :
                          wr_cmp[2*p+1] ? 1'b1 :
                          wr_cmp[2*p] ? 1'b0 : pend_reg[p];
  end

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic [1:0] els;
    assign els       = ctl_reg[i][SCT_CS_ELSB:SCT_CS_ELSA];
    assign dis[i]    = (i % 2 == 1) ? linked[i/2] : 1'b0;
    assign oc_mode[i] = ~dis[i] & (els != SCT_ELS_OFF) &
                        (ctl_reg[i][SCT_CS_MSB] | ctl_reg[i][SCT_CS_MSA]);
    assign cap_mode[i] = ~dis[i] & (els != SCT_ELS_OFF) &
                         ~ctl_reg[i][SCT_CS_MSB] & ~ctl_reg[i][SCT_CS_MSA];
    if (i % 2 == 0) begin : g_even
      assign cmp_val[i] = (linked[i/2] & sel_reg[i/2]) ? cmp_reg[i+1]
                                                        : cmp_reg[i];
    end else begin : g_odd
      assign cmp_val[i] = cmp_reg[i];
    end
    assign match[i]  = tk.tick & oc_mode[i] & (cnt_reg == cmp_val[i]);
    assign cap_ev[i] = cap_mode[i] & ~halt_reg & ~STOP_MODE & ~BREAK_STATE &
                       ((els[0] & pin_rise[i]) | (els[1] & pin_fall[i]));
    assign wr_csc[i] = wr_pend_reg & ~dis[i] &
                       (wr_addr_reg == ch_addr(SCT_CSC_BASE, i));
    assign wr_cmp[i] = wr_pend_reg & (wr_addr_reg == ch_addr(SCT_CMP_BASE, i));
    assign rd_set[i] = acc_rd & chf_reg[i] & ~dis[i] &
                       (a_addr == ch_addr(SCT_CSC_BASE, i));
    // A linked odd status register reads as zero.
    assign rd_ch[i]  =
      ((a_addr == ch_addr(SCT_CSC_BASE, i)) && !dis[i]) ?
        {24'h00_0000, chf_reg[i], ctl_reg[i]} :
      (a_addr == ch_addr(SCT_CMP_BASE, i)) ?
        {16'h0000, cmp_reg[i]} : 32'h0000_0000;

    // Pin output; overflow action takes priority over a same-tick compare.
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
        out_reg[i] <= 1'b0;
      end else if (!oc_mode[i]) begin
        out_reg[i] <= out_reg[i];
      end else if (ovf && ctl_reg[i][SCT_CS_TOV]) begin
        if (ctl_reg[i][SCT_CS_MAX]) begin
          out_reg[i] <= ~els[0];
        end else begin
          out_reg[i] <= ~out_reg[i];
        end
      end else if (match[i] && !ctl_reg[i][SCT_CS_MAX]) begin
        case (els)
          SCT_ELS_CLR: out_reg[i] <= 1'b0;
          SCT_ELS_SET: out_reg[i] <= 1'b1;
          default:     out_reg[i] <= ~out_reg[i];
        endcase
      end
    end

    // Compare values: written by software, loaded on capture.
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
        cmp_reg[i] <= '0;
      end else if (cap_ev[i]) begin
        cmp_reg[i] <= cnt_reg;
      end else if (wr_cmp[i]) begin
        cmp_reg[i] <= HWDATA[CW-1:0];
      end
    end

    // Channel control; the buffered bit exists on even channels only.
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
        ctl_reg[i] <= SCT_CSC_RST;
      end else if (wr_csc[i]) begin
        ctl_reg[i] <= HWDATA[6:0] &
                      ((i % 2 == 1) ? 7'h5F : 7'h7F);
      end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
        {chf_reg[i], chf_arm_reg[i]} <= 2'b00;
      end else begin
        {chf_reg[i], chf_arm_reg[i]} <=
          flag_step(chf_reg[i], chf_arm_reg[i], match[i] | cap_ev[i],
                    rd_set[i], wr_csc[i] & ~HWDATA[SCT_CS_FLAG], flag_ok);
      end
    end
  end

  assign CH_PIN_OUT = out_reg & ~dis;
  assign CH_PIN_OE  = oc_mode;

  // Pair selection updates at overflow to the member written last.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pend_reg <= '0;
      sel_reg  <= '0;
    end else begin
      pend_reg <= pend_next;
      sel_reg  <= linked & (ovf ? pend_next : sel_reg);
    end
  end

  // Counter; reset bit clears it even while halted.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cnt_reg <= '0;
    end else if (trst) begin
      cnt_reg <= '0;
    end else if (ovf) begin
      cnt_reg <= '0;
    end else if (tk.tick) begin
      cnt_reg <= cnt_reg + CW'(1);
    end
  end

  // Timer control fields and modulo.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      overflow_irq_enable_reg <= 1'b0;
      halt_reg <= 1'b1;
      ps_reg   <= SCT_PS_RST;
      mod_reg  <= SCT_MOD_RST;
    end else begin
      if (wr_tsc) begin
        overflow_irq_enable_reg <= HWDATA[SCT_TSC_OVERFLOW_IRQ_ENABLE];
        halt_reg <= HWDATA[SCT_TSC_HALT];
        ps_reg   <= HWDATA[2:0];
      end
      if (wr_mod) begin
        mod_reg <= HWDATA[CW-1:0];
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      {tof_reg, tof_arm_reg} <= 2'b00;
    end else begin
      {tof_reg, tof_arm_reg} <=
        flag_step(tof_reg, tof_arm_reg, ovf,
                  acc_rd & tof_reg & (a_addr == SCT_TSC_OFF),
                  wr_tsc & ~HWDATA[SCT_TSC_TOF], flag_ok);
    end
  end

  // Read data, registered in the address phase for the data phase.
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    if (a_addr == SCT_TSC_OFF) begin
      rd_word = {24'h00_0000, tof_reg, overflow_irq_enable_reg, halt_reg, 2'b00, ps_reg};
    end else if (a_addr == SCT_CNT_OFF) begin
      rd_word = {16'h0000, cnt_reg};
    end else if (a_addr == SCT_MOD_OFF) begin
      rd_word = {16'h0000, mod_reg};
    end
    for (int k = 0; k < NCH; k++) begin
      rd_word = rd_word | rd_ch[k];
    end
  end

  // Bus phases, request and pin sampling.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wr_pend_reg  <= 1'b0;
      wr_addr_reg  <= 12'h000;
      hrdata_reg   <= 32'h0000_0000;
      irq_reg      <= 1'b0;
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      pin_last_reg <= '0;
    end else begin
      wr_pend_reg  <= acc & HWRITE;
      wr_addr_reg  <= a_addr;
      hrdata_reg   <= acc_rd ? rd_word : 32'h0000_0000;
      irq_reg      <= (tof_reg & overflow_irq_enable_reg) |
                      (|(chf_reg & ~dis & {ctl_reg[5][SCT_CS_IE],
                        ctl_reg[4][SCT_CS_IE], ctl_reg[3][SCT_CS_IE],
                        ctl_reg[2][SCT_CS_IE], ctl_reg[1][SCT_CS_IE],
                        ctl_reg[0][SCT_CS_IE]}));
      pin_meta_reg <= CH_PIN_IN;
      pin_sync_reg <= pin_meta_reg;
      pin_last_reg <= pin_sync_reg;
    end
  end

  assign HRDATA    = hrdata_reg;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign TIMER_IRQ = irq_reg;
  assign WAKE_REQ  = irq_reg & WAIT_MODE;
  assign EXT_CLK_FORCE_INPUT = (ps_reg == SCT_PS_EXT);
endmodule

// File: sct_timer_checker.sv
// Port-level assertions for the six-channel PWM timer.
`timescale 1ns/1ns
module sct_timer_checker
  import sct_pkg::*;
#(
  parameter int NCH = SCT_NCH
) (
  input wire logic           CORE_CLK,
  input wire logic           RST_B,
  input wire logic           HSEL,
  input wire logic [31:0]    HADDR,
  input wire logic [1:0]     HTRANS,
  input wire logic           HWRITE,
  input wire logic [31:0]    HWDATA,
  input wire logic           HREADY,
  input wire logic [31:0]    HRDATA,
  input wire logic           HREADYOUT,
  input wire logic           HRESP,
  input wire logic           WAIT_MODE,
  input wire logic           STOP_MODE,
  input wire logic           BREAK_STATE,
  input wire logic           EXT_CLK_FORCE_INPUT,
  input wire logic [NCH-1:0] CH_PIN_OUT,
  input wire logic [NCH-1:0] CH_PIN_OE,
  input wire logic           TIMER_IRQ,
  input wire logic           WAKE_REQ
);
  logic        take;     // Address phase accepted in this cycle.
  logic        wr_pend;  // Write data phase in progress.
  logic        rd_pend;  // Read data phase in progress.
  logic        link01;   // Pair 0/1 linked by the last write.
  logic        ext_exp;  // External clock chosen by the last write.
  logic [11:0] a_q;      // Address of the current data phase.
  // Wait mode shuts the bus, so no phase is taken then.
  assign take = HSEL && HTRANS[1] && HREADY && !WAIT_MODE;
  // Track the bus so that register effects can be predicted.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      link01  <= 1'b0;
      ext_exp <= 1'b0;
      a_q     <= 12'h000;
    end else begin
      wr_pend <= take && HWRITE;
      rd_pend <= take && !HWRITE;
      if (take) begin
        a_q <= HADDR[11:0];
      end
      if (wr_pend && a_q == SCT_CSC_BASE) begin
        link01 <= HWDATA[SCT_CS_MSB];
      end
      if (wr_pend && a_q == SCT_TSC_OFF) begin
        ext_exp <= HWDATA[2:0] == SCT_PS_EXT;
      end
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  bus_okay_a: assert property (HREADYOUT && !HRESP)
    else $error("slave stalled or answered with an error");
  idle_data_a: assert property (!rd_pend |-> HRDATA == 32'h0000_0000)
    else $error("read data outside a read data phase");
  unmapped_zero_a: assert property (
    rd_pend && a_q == 12'h00C |-> HRDATA == 32'h0000_0000)
    else $error("unmapped read not zero");
  odd_read_zero_a: assert property (
    rd_pend && link01 && a_q == 12'h014 |-> HRDATA == 32'h0000_0000)
    else $error("linked odd register not idle");
  odd_pin_free_a: assert property (
    link01 |-> !CH_PIN_OE[1] && !CH_PIN_OUT[1])
    else $error("linked odd pin still driven");
  ext_input_a: assert property (EXT_CLK_FORCE_INPUT == ext_exp)
    else $error("clock pin direction does not follow prescaler code");
  wait_wake_a: assert property (WAKE_REQ == (TIMER_IRQ && WAIT_MODE))
    else $error("wake request not gated by wait mode");
  stop_hold_a: assert property (
    (STOP_MODE && !wr_pend)[*3] |-> $stable(TIMER_IRQ) && $stable(CH_PIN_OUT))
    else $error("timer active in stop mode");
  break_hold_a: assert property (
    (BREAK_STATE && !wr_pend)[*3] |-> $stable(CH_PIN_OUT))
    else $error("outputs moved during break");
endmodule

bind sct_timer sct_timer_checker #(.NCH(NCH)) u_chk (
  .CORE_CLK(CORE_CLK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
  .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .WAIT_MODE(WAIT_MODE), .STOP_MODE(STOP_MODE), .BREAK_STATE(BREAK_STATE),
  .EXT_CLK_FORCE_INPUT(EXT_CLK_FORCE_INPUT), .CH_PIN_OUT(CH_PIN_OUT),
  .CH_PIN_OE(CH_PIN_OE), .TIMER_IRQ(TIMER_IRQ), .WAKE_REQ(WAKE_REQ));

// File: sct_load_model.sv
// Pin loads and external clock source around the timer.
`timescale 1ns/1ns
module sct_load_model #(
  parameter int HALF = 37
) (
  input  wire logic       force_in,
  input  wire logic [5:0] ch_out,
  input  wire logic [5:0] ch_oe,
  input  wire logic [5:0] drv,
  output logic            ext_clk,
  output logic [5:0]      pin_lvl
);
  // released pins
  // Each pin has a pull-down, so a pin nobody drives reads 0.
  assign pin_lvl = (ch_oe & ch_out) | (~ch_oe & drv);
  // clock source
  // The source only runs while the timer takes the pin as input; the
  // odd half period keeps it unrelated in phase to the core clock.
  initial begin
    ext_clk = 1'b0;
    forever begin
      #HALF;
      ext_clk = force_in ? !ext_clk : 1'b0;
    end
  end
endmodule

// File: sct_timer_tb.sv
// Self-checking bench for the six-channel PWM timer over AHB-Lite.
`timescale 1ns/1ns
module sct_timer_tb
  import sct_pkg::*;
;
  localparam int EXT_HALF = 37;  // External clock half period in ns.
  logic        clk, rst_b, hsel, hwrite, hready, wait_m, stop_m, brk;
  logic        bce, ext_clk, force_in, irq, wake;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, q, c0;
  logic [5:0]  drv, ch_out, ch_oe, lvl;
  int          num_errors, num_checks, h, e;
  logic [7:0]  mode [4] = '{8'h1A, 8'h1E, 8'h18, 8'h1B};
  int          hi [4] = '{30, 70, 0, 100};  // High cycles in 100.
  sct_timer u_dut (
    .CORE_CLK(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(),
    .WAIT_MODE(wait_m), .STOP_MODE(stop_m), .BREAK_STATE(brk),
    .BREAK_CLEAR_ENABLE(bce), .EXT_CLK_PIN(ext_clk),
    .EXT_CLK_FORCE_INPUT(force_in), .CH_PIN_IN(lvl), .CH_PIN_OUT(ch_out),
    .CH_PIN_OE(ch_oe), .TIMER_IRQ(irq), .WAKE_REQ(wake));
  sct_load_model #(.HALF(EXT_HALF)) u_load (.force_in(force_in),
    .ch_out(ch_out), .ch_oe(ch_oe), .drv(drv), .ext_clk(ext_clk),
    .pin_lvl(lvl));
  // Free-running core clock.
  always #5 clk = !clk;
  function automatic logic [11:0] csc(input int ch);
    return SCT_CSC_BASE + SCT_STRIDE * 12'(ch);
  endfunction
  function automatic logic [11:0] cmp(input int ch);
    return SCT_CMP_BASE + SCT_STRIDE * 12'(ch);
  endfunction
  // Waits for the slave to be ready; only the watchdog ends a hang.
  task automatic wait_rdy;
    do begin
      @(posedge clk);
    end while (hready !== 1'b1);
  endtask
  // One single word transfer; read data is taken at the final edge.
  task automatic bus(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {20'h0_0000, a};
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0000_0000);
    chk(q, exp);
  endtask
  // Counts high cycles of a pin over ten periods of ten cycles.
  task automatic duty(input int ch, input int exp);
    h = 0;
    repeat (20) @(posedge clk);
    repeat (100) begin
      @(posedge clk);
      if (lvl[ch] === 1'b1) h++;
    end
    chk(32'(h), 32'(exp));
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Watchdog: the tests need well under 10000 cycles.
  initial begin
    #200000;
    num_errors++;
    end_of_test();
  end
  initial begin
    {clk, rst_b, hsel, hwrite, wait_m, stop_m, brk, bce} = 8'h00;
    {htrans, haddr, hwdata, drv, num_errors, num_checks} = '0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rd(SCT_TSC_OFF, 32'h0000_0020);
    rd(SCT_MOD_OFF, 32'h0000_FFFF);
    rd(12'h00C, 32'h0000_0000);
    // Each divider and the pin clock, run over a fixed span.
    for (int c = 0; c < 8; c++) begin
      wr(SCT_TSC_OFF, 32'h0000_0030 | 32'(c));
      wr(SCT_TSC_OFF, 32'(c));
      repeat (128) @(posedge clk);
      wr(SCT_TSC_OFF, 32'h0000_0020 | 32'(c));
      chk({31'h0, force_in}, 32'(c == 7));
      e = (c == 7) ? 1310 / (2 * EXT_HALF) : 131 >> c;
      bus(SCT_CNT_OFF, 1'b0, 32'h0000_0000);
      chk(32'(q + 32'h0000_0002 - 32'(e) <= 32'h0000_0004), 32'h1);
    end
    // Unbuffered PWM on channel 2; toggle on compare is never chosen.
    wr(SCT_TSC_OFF, 32'h0000_0030);
    wr(SCT_MOD_OFF, 32'h0000_0009);
    wr(cmp(2), 32'h0000_0002);
    wr(SCT_TSC_OFF, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      wr(csc(2), {24'h00_0000, mode[i]});
      duty(2, hi[i]);
    end
    // Buffered PWM on every pair; the middle pair also sets the
    // unbuffered bit, which the buffered bit must override.
    for (int p = 0; p < 6; p += 2) begin
      wr(SCT_TSC_OFF, 32'h0000_0030);
      wr(cmp(p), 32'h0000_0002);
      wr(csc(p), p == 2 ? 32'h0000_003A : 32'h0000_002A);
      wr(SCT_TSC_OFF, 32'h0000_0000);
      duty(p, 30);
      wr(csc(p + 1), 32'h0000_001A);
      rd(csc(p + 1), 32'h0000_0000);
      chk({31'h0, ch_oe[p+1]}, 32'h0);
      wr(cmp(p + 1), 32'h0000_0006);
      duty(p, 70);
      wr(cmp(p), 32'h0000_0004);
      duty(p, 50);
      wr(csc(p), 32'h0000_0000);
    end
    // Overflow flag, its enable, wake-up and the clearing sequence.
    wr(SCT_TSC_OFF, 32'h0000_0020);
    rd(SCT_TSC_OFF, 32'h0000_00A0);
    wr(SCT_TSC_OFF, 32'h0000_00E0);
    rd(SCT_TSC_OFF, 32'h0000_00E0);
    chk({30'h0, wake, irq}, 32'h1);
    wait_m <= 1'b1;
    rd(SCT_TSC_OFF, 32'h0000_0000);
    chk({30'h0, wake, irq}, 32'h3);
    wait_m <= 1'b0;
    wr(SCT_TSC_OFF, 32'h0000_0060);
    rd(SCT_TSC_OFF, 32'h0000_0060);
    chk({30'h0, wake, irq}, 32'h0);
    // A clear armed before a break completes only after it.
    wr(SCT_TSC_OFF, 32'h0000_0000);
    repeat (20) @(posedge clk);
    wr(SCT_TSC_OFF, 32'h0000_0020);
    rd(SCT_TSC_OFF, 32'h0000_00A0);
    brk <= 1'b1;
    rd(SCT_TSC_OFF, 32'h0000_00A0);
    wr(SCT_TSC_OFF, 32'h0000_0020);
    rd(SCT_TSC_OFF, 32'h0000_00A0);
    brk <= 1'b0;
    wr(SCT_TSC_OFF, 32'h0000_0020);
    rd(SCT_TSC_OFF, 32'h0000_0020);
    // Stop and break freeze the counter, which then resumes.
    wr(SCT_MOD_OFF, 32'h0000_FFFF);
    wr(SCT_TSC_OFF, 32'h0000_0000);
    for (int m = 0; m < 2; m++) begin
      {stop_m, brk} <= (m == 0) ? 2'b10 : 2'b01;
      bus(SCT_CNT_OFF, 1'b0, 32'h0000_0000);
      c0 = q;
      repeat (30) @(posedge clk);
      rd(SCT_CNT_OFF, c0);
      {stop_m, brk} <= 2'b00;
      bus(SCT_CNT_OFF, 1'b0, 32'h0000_0000);
      chk(32'(q > c0), 32'h1);
    end
    // A rising edge on channel 4 captures and raises its request. The
    // flag left over from the compare run is cleared first, inside a
    // break that allows clearing, so the capture must set it anew.
    {brk, bce} <= 2'b11;
    rd(csc(4), 32'h0000_0080);
    wr(csc(4), 32'h0000_0044);
    {brk, bce} <= 2'b00;
    rd(csc(4), 32'h0000_0044);
    chk({31'h0, irq}, 32'h0);
    drv <= 6'h10;
    repeat (10) @(posedge clk);
    rd(csc(4), 32'h0000_00C4);
    chk({31'h0, irq}, 32'h1);
    end_of_test();
  end
endmodule
